// ==== abz_field_pkg.sv ====
// Shared constants and types for the quadrature encoder and field flag block.
`default_nettype none

package abz_field_pkg;

  // ****************************************************************
  // Register addresses on the serial port
  // ****************************************************************
  localparam logic [4:0] ADDR_PULSES_PER_TURN_LOW  = 5'h04;
  localparam logic [4:0] ADDR_PULSES_PER_TURN_HIGH = 5'h05;
  localparam logic [4:0] ADDR_FIELD_THRESHOLDS     = 5'h06;
  localparam logic [4:0] ADDR_FIELD_FLAGS          = 5'h1B;

  // ****************************************************************
  // Reset values and field positions
  // ****************************************************************
  localparam logic [7:0] RST_PULSES_PER_TURN_LOW  = 8'hC0;
  localparam logic [7:0] RST_PULSES_PER_TURN_HIGH = 8'h0F;
  localparam logic [7:0] RST_FIELD_THRESHOLDS     = 8'h1C;

  localparam int PPT_LOW_MSB       = 7;
  localparam int PPT_LOW_LSB       = 6;
  localparam int PPT_HIGH_MSB      = 3;
  localparam int PPT_HIGH_LSB      = 0;
  localparam int INDEX_SHAPE_MSB   = 7;
  localparam int INDEX_SHAPE_LSB   = 4;
  localparam int LOW_THR_MSB       = 7;
  localparam int LOW_THR_LSB       = 5;
  localparam int HIGH_THR_MSB      = 4;
  localparam int HIGH_THR_LSB      = 2;
  localparam int FLAG_HIGH_BIT     = 7;
  localparam int FLAG_LOW_BIT      = 6;

  // ****************************************************************
  // Serial frame layout
  // ****************************************************************
  localparam int         FRAME_BITS = 16;
  localparam logic [2:0] CMD_READ   = 3'h2;
  localparam logic [2:0] CMD_WRITE  = 3'h4;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int unsigned CLK_FREQ_MHZ    = 100;
  localparam int unsigned UPDATE_FREQ_MHZ = 16;
  localparam int unsigned WRITE_TIME_MS   = 20;
  localparam int unsigned WRITE_CYCLES    = WRITE_TIME_MS * CLK_FREQ_MHZ * 1000;
  localparam logic [7:0]  ANGLE_HYST_LSB  = 8'h01;

  // ****************************************************************
  // Field trip points in mT, indexed by threshold code
  // ****************************************************************
  localparam logic [7:0] RISE_TRIP_MT [8] = '{8'h1A, 8'h29, 8'h38, 8'h46,
                                              8'h54, 8'h62, 8'h70, 8'h7E};
  localparam logic [7:0] FALL_TRIP_MT [8] = '{8'h14, 8'h23, 8'h32, 8'h40,
                                              8'h4E, 8'h5C, 8'h6A, 8'h78};

  typedef enum logic [1:0] {
    NVM_IDLE = 2'b00,
    NVM_BUSY = 2'b01
  } nvm_state_t;

endpackage

`default_nettype wire

// ==== update_tick_gen.sv ====
// Fractional divider giving the 16 MHz update enable from the reference clock.
`default_nettype none

module update_tick_gen
  import abz_field_pkg::*;
(
  input  wire logic ref_clk_in,
  input  wire logic rstn_in,
  output var  logic tick_out
);

  // The ratio is not whole, so a phase accumulator spreads the ticks evenly.
  localparam logic [7:0] STEP   = 8'(UPDATE_FREQ_MHZ);
  localparam logic [7:0] MODULO = 8'(CLK_FREQ_MHZ);

  logic [7:0] phase_r;
  logic [7:0] phase_sum;
  logic       wrap;

  assign phase_sum = phase_r + STEP;
  assign wrap      = (phase_sum >= MODULO);

  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      phase_r  <= 8'h00;
      tick_out <= 1'b0;
    end else begin
      phase_r  <= wrap ? (phase_sum - MODULO) : phase_sum;
      tick_out <= wrap;
    end
  end

endmodule // update_tick_gen

`default_nettype wire

// ==== field_flag_detect.sv ====
// One field strength flag with a rising and a falling trip point.
`default_nettype none

module field_flag_detect
  import abz_field_pkg::*;
#(
  parameter bit DETECT_HIGH = 1'b1
) (
  input  wire logic       ref_clk_in,
  input  wire logic       rstn_in,
  input  wire logic [7:0] field_in,
  input  wire logic [2:0] code_in,
  output var  logic       flag_out
);

  logic [7:0] rise_trip;
  logic [7:0] fall_trip;
  logic       above_rise;
  logic       below_fall;

  assign rise_trip  = RISE_TRIP_MT[code_in];
  assign fall_trip  = FALL_TRIP_MT[code_in];
  assign above_rise = (field_in > rise_trip);
  assign below_fall = (field_in < fall_trip);

  // Between the two trip points the flag keeps its state.
  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      flag_out <= 1'b0;
    end else if (DETECT_HIGH) begin
      if (above_rise) begin
        flag_out <= 1'b1;
      end else if (below_fall) begin
        flag_out <= 1'b0;
      end
    end else begin
      if (below_fall) begin
        flag_out <= 1'b1;
      end else if (above_rise) begin
        flag_out <= 1'b0;
      end
    end
  end

endmodule // field_flag_detect

`default_nettype wire

// ==== abz_encoder_and_field_flags.sv ====
// Quadrature encoder output, index, field flags and serial register access.
`default_nettype none

// Notes on behaviour
// - A and B square waves, quarter shifted
// - N pulses per turn, 1 to 64
// - Pulse count code split over 0x4, 0x5
// - Code k gives k+1 pulses, 4(k+1) edges
// - Reset default is 64 pulses per turn
// - Index once per turn at zero
// - Index shape field in register 0x5
// - Shape 0000: rise at B fall, half pulse
// - Angular hysteresis stops edge chatter
// - Output state recomputed at 16 MHz
// - High flag sets above high trip
// - Low flag sets below low trip
// - Both threshold codes in register 6
// - Eight codes, 26 to 126 mT, 6 lower falling
// - Flags use rising and falling trip points
// - Flags evaluated independently of each other
// - Flags in register 27 and on pins
// - Read of 27 answered next frame
module abz_encoder_and_field_flags
  import abz_field_pkg::*;
#(
  parameter int unsigned WRITE_WAIT_CYCLES = WRITE_CYCLES,
  parameter logic [7:0]  HYST_LSB          = ANGLE_HYST_LSB
) (
  input  wire logic       ref_clk_in,
  input  wire logic       rstn_in,
  input  wire logic [7:0] angle_in,
  input  wire logic [7:0] field_strength_in,
  input  wire logic       spi_sclk_in,
  input  wire logic       spi_cs_n_in,
  input  wire logic       spi_mosi_in,
  output var  logic       spi_miso_out,
  output var  logic       spi_miso_oe_out,
  output var  logic       enc_a_out,
  output var  logic       enc_b_out,
  output var  logic       enc_z_out,
  output var  logic       field_high_flag_out,
  output var  logic       field_low_flag_out
);

  import abz_field_pkg::*;

  // ****************************************************************
  // Functions for position arithmetic
  // ****************************************************************
  // Quarter-period index of an angle for a given edge count per turn.
  function automatic logic [7:0] quarter_of(input logic [7:0] ang, input logic [8:0] edges);
    logic [16:0] prod;
    prod = {9'h000, ang} * {8'h00, edges};
    return prod[15:8];
  endfunction

  // Distance x minus y, folded into the range 0 to edges-1.
  function automatic logic [7:0] mod_sub(input logic [7:0] x, input logic [7:0] y,
                                         input logic [8:0] edges);
    logic [8:0] diff;
    diff = {1'b0, x} - {1'b0, y};
    if (x < y) begin
      diff = diff + edges;
    end
    return diff[7:0];
  endfunction

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  localparam int PIN_SCLK = 0;
  localparam int PIN_CS_N = 1;
  localparam int PIN_MOSI = 2;

  logic [2:0] pin_raw;
  logic [2:0] pin_lvl_r;
  logic [2:0] pin_lvl_nxt;

  assign pin_raw = {spi_mosi_in, spi_cs_n_in, spi_sclk_in};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_pin_sync
      logic [2:0] sync_r;
      always_ff @(posedge ref_clk_in) begin
        if (!rstn_in) begin
          sync_r <= (gi == PIN_CS_N) ? 3'h7 : 3'h0;
        end else begin
          sync_r <= {sync_r[1:0], pin_raw[gi]};
        end
      end
      // A change counts only once the second and third stages agree.
      assign pin_lvl_nxt[gi] = (sync_r[1] == sync_r[2]) ? sync_r[2] : pin_lvl_r[gi];
      always_ff @(posedge ref_clk_in) begin
        if (!rstn_in) begin
          pin_lvl_r[gi] <= (gi == PIN_CS_N) ? 1'b1 : 1'b0;
        end else begin
          pin_lvl_r[gi] <= pin_lvl_nxt[gi];
        end
      end
    end
  endgenerate

  logic cs_active;
  logic cs_fall;
  logic cs_rise;
  logic sclk_rise;
  logic sclk_fall;

  assign cs_active = ~pin_lvl_r[PIN_CS_N];
  assign cs_fall   = pin_lvl_r[PIN_CS_N] & ~pin_lvl_nxt[PIN_CS_N];
  assign cs_rise   = ~pin_lvl_r[PIN_CS_N] & pin_lvl_nxt[PIN_CS_N];
  assign sclk_rise = cs_active & ~pin_lvl_r[PIN_SCLK] & pin_lvl_nxt[PIN_SCLK];
  assign sclk_fall = cs_active & pin_lvl_r[PIN_SCLK] & ~pin_lvl_nxt[PIN_SCLK];

  // ****************************************************************
  // Configuration registers
  // ****************************************************************
  logic [1:0] ppt_low_r;
  logic [3:0] ppt_high_r;
  logic [3:0] index_shape_r;
  logic [2:0] low_thr_r;
  logic [2:0] high_thr_r;
  logic       field_high_flag;
  logic       field_low_flag;

  logic [7:0] flags_word;
  assign flags_word = {field_high_flag, field_low_flag, 6'h00};

  function automatic logic [7:0] reg_image(input logic [4:0] addr, input logic [1:0] p_lo,
                                           input logic [3:0] p_hi, input logic [3:0] shape,
                                           input logic [2:0] lo_t, input logic [2:0] hi_t,
                                           input logic [7:0] flags);
    logic [7:0] word;
    word = 8'h00;
    case (addr)
      ADDR_PULSES_PER_TURN_LOW: begin
        word[PPT_LOW_MSB:PPT_LOW_LSB] = p_lo;
      end
      ADDR_PULSES_PER_TURN_HIGH: begin
        word[PPT_HIGH_MSB:PPT_HIGH_LSB]       = p_hi;
        word[INDEX_SHAPE_MSB:INDEX_SHAPE_LSB] = shape;
      end
      ADDR_FIELD_THRESHOLDS: begin
        word[LOW_THR_MSB:LOW_THR_LSB]   = lo_t;
        word[HIGH_THR_MSB:HIGH_THR_LSB] = hi_t;
      end
      ADDR_FIELD_FLAGS: begin
        word = flags;
      end
      default: begin
        word = 8'h00;
      end
    endcase
    return word;
  endfunction

  // ****************************************************************
  // Serial frame shifter
  // ****************************************************************
  logic [15:0] rx_shift_r;
  logic [15:0] tx_shift_r;
  logic [4:0]  bit_cnt_r;
  logic        resp_is_reg_r;
  logic [4:0]  resp_addr_r;
  logic [15:0] resp_word;
  logic [7:0]  resp_reg_data;
  logic        frame_done;
  logic [2:0]  frame_cmd;
  logic [4:0]  frame_addr;
  logic [7:0]  frame_value;

  localparam logic [4:0] FULL_FRAME = 5'(FRAME_BITS);

  assign frame_done  = cs_rise & (bit_cnt_r == FULL_FRAME);
  assign frame_cmd   = rx_shift_r[15:13];
  assign frame_addr  = rx_shift_r[12:8];
  assign frame_value = rx_shift_r[7:0];

  // answer built when the next frame opens
  assign resp_reg_data = reg_image(resp_addr_r, ppt_low_r, ppt_high_r, index_shape_r,
                                   low_thr_r, high_thr_r, flags_word);
  assign resp_word     = resp_is_reg_r ? {resp_reg_data, 8'h00} : {angle_in, 8'h00};

  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      rx_shift_r      <= 16'h0000;
      tx_shift_r      <= 16'h0000;
      bit_cnt_r       <= 5'h00;
      spi_miso_out    <= 1'b0;
      spi_miso_oe_out <= 1'b0;
    end else if (cs_fall) begin
      tx_shift_r      <= resp_word;
      spi_miso_out    <= resp_word[15];
      bit_cnt_r       <= 5'h00;
      spi_miso_oe_out <= 1'b1;
    end else if (cs_rise) begin
      spi_miso_oe_out <= 1'b0;
    end else begin
      if (sclk_rise) begin
        rx_shift_r <= {rx_shift_r[14:0], pin_lvl_r[PIN_MOSI]};
        if (bit_cnt_r != FULL_FRAME) begin
          bit_cnt_r <= bit_cnt_r + 5'h01;
        end
      end
      if (sclk_fall && (bit_cnt_r != 5'h00)) begin
        tx_shift_r   <= {tx_shift_r[14:0], 1'b0};
        spi_miso_out <= tx_shift_r[14];
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      resp_is_reg_r <= 1'b0;
      resp_addr_r   <= 5'h00;
    end else if (frame_done) begin
      resp_is_reg_r <= (frame_cmd == CMD_READ) || (frame_cmd == CMD_WRITE);
      resp_addr_r   <= frame_addr;
    end
  end

  // ****************************************************************
  // Nonvolatile store emulation
  // ****************************************************************
  // A write lands only after the store time, so an early readback shows the old value.
  nvm_state_t  nvm_state_r;
  logic [21:0] nvm_cnt_r;
  logic [4:0]  wr_addr_r;
  logic [7:0]  wr_data_r;
  logic        wr_start;
  logic        commit;

  localparam logic [21:0] WAIT_LAST = 22'(WRITE_WAIT_CYCLES - 1);

  assign wr_start = frame_done && (frame_cmd == CMD_WRITE) && (nvm_state_r == NVM_IDLE);
  assign commit   = (nvm_state_r == NVM_BUSY) && (nvm_cnt_r == WAIT_LAST);

  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      nvm_state_r <= NVM_IDLE;
      nvm_cnt_r   <= 22'h000000;
      wr_addr_r   <= 5'h00;
      wr_data_r   <= 8'h00;
    end else begin
      case (nvm_state_r)
        NVM_IDLE: begin
          nvm_cnt_r <= 22'h000000;
          if (wr_start) begin
            wr_addr_r   <= frame_addr;
            wr_data_r   <= frame_value;
            nvm_state_r <= NVM_BUSY;
          end
        end
        NVM_BUSY: begin
          nvm_cnt_r <= nvm_cnt_r + 22'h000001;
          if (commit) begin
            nvm_state_r <= NVM_IDLE;
          end
        end
        default: begin
          nvm_state_r <= NVM_IDLE;
        end
      endcase
    end
  end

  // pulse count code split over two registers
  // low six bits are not stored
  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      ppt_low_r     <= RST_PULSES_PER_TURN_LOW[PPT_LOW_MSB:PPT_LOW_LSB];
      ppt_high_r    <= RST_PULSES_PER_TURN_HIGH[PPT_HIGH_MSB:PPT_HIGH_LSB];
      index_shape_r <= RST_PULSES_PER_TURN_HIGH[INDEX_SHAPE_MSB:INDEX_SHAPE_LSB];
      low_thr_r     <= RST_FIELD_THRESHOLDS[LOW_THR_MSB:LOW_THR_LSB];
      high_thr_r    <= RST_FIELD_THRESHOLDS[HIGH_THR_MSB:HIGH_THR_LSB];
    end else if (commit) begin
      if (wr_addr_r == ADDR_PULSES_PER_TURN_LOW) begin
        ppt_low_r <= wr_data_r[PPT_LOW_MSB:PPT_LOW_LSB];
      end
      if (wr_addr_r == ADDR_PULSES_PER_TURN_HIGH) begin
        ppt_high_r    <= wr_data_r[PPT_HIGH_MSB:PPT_HIGH_LSB];
        index_shape_r <= wr_data_r[INDEX_SHAPE_MSB:INDEX_SHAPE_LSB];
      end
      if (wr_addr_r == ADDR_FIELD_THRESHOLDS) begin
        low_thr_r  <= wr_data_r[LOW_THR_MSB:LOW_THR_LSB];
        high_thr_r <= wr_data_r[HIGH_THR_MSB:HIGH_THR_LSB];
      end
    end
  end

  // ****************************************************************
  // Quadrature position tracking
  // ****************************************************************
  logic       update_tick;
  logic [5:0] pulses_per_turn_code;
  logic [8:0] edges_per_turn;
  logic [7:0] pos_r;
  logic [7:0] pos_nxt;
  logic [7:0] q_minus;
  logic [7:0] q_plus;
  logic [7:0] q_now;
  logic [7:0] last_pos;
  logic       pos_hold;
  logic       step_fwd;
  logic       pos_out_of_range;

  update_tick_gen u_update_tick (
    .ref_clk_in (ref_clk_in),
    .rstn_in    (rstn_in),
    .tick_out   (update_tick)
  );

  assign pulses_per_turn_code = {ppt_high_r, ppt_low_r};
  assign edges_per_turn       = ({3'h0, pulses_per_turn_code} + 9'h001) << 2;
  assign last_pos             = 8'(edges_per_turn - 9'h001);

  // window of plus and minus hysteresis
  assign q_minus  = quarter_of(angle_in - HYST_LSB, edges_per_turn);
  assign q_plus   = quarter_of(angle_in + HYST_LSB, edges_per_turn);
  assign q_now    = quarter_of(angle_in, edges_per_turn);
  assign pos_hold = mod_sub(pos_r, q_minus, edges_per_turn)
                    <= mod_sub(q_plus, q_minus, edges_per_turn);
  assign step_fwd = mod_sub(q_minus, pos_r, edges_per_turn)
                    <= mod_sub(pos_r, q_plus, edges_per_turn);
  assign pos_out_of_range = ({1'b0, pos_r} >= edges_per_turn);

  // One quarter step per update unless the position lies past the turn end, so a large jump walks through every edge.
  always_comb begin
    pos_nxt = pos_r;
    if (pos_out_of_range) begin
      pos_nxt = q_now;
    end else if (!pos_hold) begin
      if (step_fwd) begin
        pos_nxt = (pos_r == last_pos) ? 8'h00 : pos_r + 8'h01;
      end else begin
        pos_nxt = (pos_r == 8'h00) ? last_pos : pos_r - 8'h01;
      end
    end
  end

  // position moves only on the update tick
  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      pos_r <= 8'h00;
    end else if (update_tick) begin
      pos_r <= pos_nxt;
    end
  end

  // ****************************************************************
  // Output shaping
  // ****************************************************************
  logic [7:0] index_offset;
  logic [7:0] index_width;
  logic [7:0] index_rel;

  // default offset 0 and width of two quarters
  assign index_offset = {6'h00, index_shape_r[1:0]};
  assign index_width  = {6'h00, index_shape_r[3:2] + 2'h1} + 8'h01;
  assign index_rel    = mod_sub(pos_r, index_offset, edges_per_turn);

  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      enc_a_out <= 1'b0;
      enc_b_out <= 1'b0;
      enc_z_out <= 1'b0;
    end else begin
      // Gray sequence keeps B a quarter behind A
      enc_a_out <= pos_r[0] ^ pos_r[1];
      enc_b_out <= pos_r[1];
      // index tied to start of turn
      enc_z_out <= (index_rel < index_width);
    end
  end

  // ****************************************************************
  // Field flags
  // ****************************************************************
  // high flag detector
  field_flag_detect #(
    .DETECT_HIGH (1'b1)
  ) u_flag_high (
    .ref_clk_in (ref_clk_in),
    .rstn_in    (rstn_in),
    .field_in   (field_strength_in),
    .code_in    (high_thr_r),
    .flag_out   (field_high_flag)
  );

  field_flag_detect #(
    .DETECT_HIGH (1'b0)
  ) u_flag_low (
    .ref_clk_in (ref_clk_in),
    .rstn_in    (rstn_in),
    .field_in   (field_strength_in),
    .code_in    (low_thr_r),
    .flag_out   (field_low_flag)
  );

  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      field_high_flag_out <= 1'b0;
      field_low_flag_out  <= 1'b0;
    end else begin
      field_high_flag_out <= field_high_flag;
      field_low_flag_out  <= field_low_flag;
    end
  end

endmodule // abz_encoder_and_field_flags

`default_nettype wire

// ==== abz_encoder_and_field_flags_unused_marker.sv ====
// Empty compilation unit that holds no logic.
`default_nettype none
`default_nettype wire

// ==== abz_field_sva.sv ====
// Checker for quadrature, index, field flag and select timing.
`default_nettype none

module abz_field_sva (
  input wire logic       ref_clk_in,
  input wire logic       rstn_in,
  input wire logic [7:0] field_strength_in,
  input wire logic       spi_cs_n_in,
  input wire logic       spi_miso_oe_out,
  input wire logic       enc_a_out,
  input wire logic       enc_b_out,
  input wire logic       enc_z_out,
  input wire logic       field_high_flag_out,
  input wire logic       field_low_flag_out
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rstn_in);

  // Above every rising trip point, or below every falling one, for any code.
  sequence s_hot;
    (field_strength_in > 8'h7E) [*4];
  endsequence
  sequence s_cold;
    (field_strength_in < 8'h14) [*4];
  endsequence

  a_edge_gap: assert property (
    $changed({enc_a_out, enc_b_out}) |=> $stable({enc_a_out, enc_b_out}) [*5])
    else $error("quadrature edges closer than one update period");
  a_quad_step: assert property (
    $changed(enc_a_out) |-> $stable(enc_b_out))
    else $error("A and B changed together");
  // The index level taken on just after reset comes with no quadrature step.
  a_index_step: assert property (
    ($changed(enc_z_out) && $past(rstn_in, 2)) |-> $changed({enc_a_out, enc_b_out}))
    else $error("index moved off a quadrature step");
  a_high_sets: assert property (
    s_hot |-> field_high_flag_out)
    else $error("high flag not set by strong field");
  a_low_sets: assert property (
    s_cold |-> field_low_flag_out)
    else $error("low flag not set by weak field");
  a_high_clears: assert property (
    s_cold |-> !field_high_flag_out)
    else $error("high flag kept in weak field");
  a_low_clears: assert property (
    s_hot |-> !field_low_flag_out)
    else $error("low flag kept in strong field");
  a_idle_release: assert property (
    spi_cs_n_in [*6] |-> !spi_miso_oe_out)
    else $error("data out driven while deselected");
  a_select_drive: assert property (
    (!spi_cs_n_in) [*6] |-> spi_miso_oe_out)
    else $error("data out not driven while selected");
endmodule // abz_field_sva

bind abz_encoder_and_field_flags abz_field_sva u_abz_field_sva (.ref_clk_in, .rstn_in,
  .field_strength_in, .spi_cs_n_in,
  .spi_miso_oe_out, .enc_a_out, .enc_b_out, .enc_z_out, .field_high_flag_out,
  .field_low_flag_out);

`default_nettype wire

// ==== abz_spi_host.sv ====
// Serial host model that frames register reads and writes.
`default_nettype none

module abz_spi_host #(
  parameter int unsigned WAIT = 50
) (
  input  wire logic clk_in,
  input  wire logic miso_in,
  output var  logic sclk_out,
  output var  logic cs_n_out,
  output var  logic mosi_out
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
    mosi_out = 1'b0;
  end

  task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
    @(posedge clk_in);
    cs_n_out <= 1'b0;
    mosi_out <= tx[15];
    repeat (8) @(posedge clk_in);
    for (int i = 15; i >= 0; i--) begin
      sclk_out <= 1'b1;
      rx[i] = miso_in;
      repeat (6) @(posedge clk_in);
      sclk_out <= 1'b0;
      if (i > 0) mosi_out <= tx[i-1];
      repeat (6) @(posedge clk_in);
    end
    cs_n_out <= 1'b1;
    // A released data line is not left at its last level.
    mosi_out <= ~mosi_out;
    repeat (6) @(posedge clk_in);
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] v);
    logic [15:0] r;
    xfer({3'b100, a, v}, r);
    repeat (WAIT + 4) @(posedge clk_in);
  endtask
endmodule // abz_spi_host

`default_nettype wire

// ==== abz_encoder_and_field_flags_tb_top.sv ====
// Testbench for the quadrature encoder and field flag block.
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin miscompares++; \
  $display("mismatch t=%0t got=%0h exp=%0h", $time, g, e); end end

module abz_encoder_and_field_flags_tb_top import abz_field_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk_in, rstn_in, spi_sclk_in, spi_cs_n_in, spi_mosi_in, spi_miso_out;
  logic spi_miso_oe_out, enc_a_out, enc_b_out, enc_z_out;
  logic field_high_flag_out, field_low_flag_out, a_q, b_q, z_q, eh, el;
  logic [7:0] angle_in, field_strength_in;
  int miscompares, check_count, n_fwd, n_rev, n_z;
  localparam logic [4:0] RA [5] = '{5'h05, 5'h06, 5'h1F, 5'h1B, 5'h04};
  localparam logic [7:0] EV [5] = '{8'hC0, 8'h0F, 8'h1C, 8'h00, 8'h00};

  abz_encoder_and_field_flags #(.WRITE_WAIT_CYCLES(50)) u_abz_encoder_and_field_flags (
    .ref_clk_in, .rstn_in, .angle_in, .field_strength_in, .spi_sclk_in, .spi_cs_n_in,
    .spi_mosi_in, .spi_miso_out, .spi_miso_oe_out, .enc_a_out, .enc_b_out, .enc_z_out,
    .field_high_flag_out, .field_low_flag_out);
  abz_spi_host #(.WAIT(50)) u_host (.clk_in(ref_clk_in), .miso_in(spi_miso_out),
    .sclk_out(spi_sclk_in), .cs_n_out(spi_cs_n_in), .mosi_out(spi_mosi_in));

  initial begin
    ref_clk_in = 1'b0;
    forever #5 ref_clk_in = ~ref_clk_in;
  end

  always @(posedge ref_clk_in) begin
    if (enc_a_out && !a_q) begin
      if (enc_b_out) n_rev++;
      else n_fwd++;
    end
    if (enc_z_out && !z_q) begin
      // The index level taken on just after reset follows no B edge.
      if (n_z > 0) `CHK({b_q, enc_b_out}, 2'b10)
      n_z++;
    end
    a_q <= enc_a_out;
    b_q <= enc_b_out;
    z_q <= enc_z_out;
  end

  function automatic logic nxt(logic p, logic [7:0] v, logic [2:0] c, logic hi);
    if (v > RISE_TRIP_MT[c]) return hi;
    if (v < FALL_TRIP_MT[c]) return !hi;
    return p;
  endfunction

  // Two turns up then two down; the second turn of each is counted.
  task automatic sweep(input int k);
    int f, r, zc;
    for (int i = 0; i <= 1024; i++) begin
      if (i % 512 == 256) begin
        f = n_fwd;
        r = n_rev;
        zc = n_z;
      end
      if (i % 512 == 0 && i > 0) begin
        `CHK(n_fwd - f, (i == 512) ? k + 1 : 0)
        `CHK(n_rev - r, (i == 512) ? 0 : k + 1)
        `CHK(n_z - zc, 1)
      end
      if (i < 1024) angle_in <= (i < 512) ? i[7:0] : 8'(1023 - i);
      repeat (16) @(posedge ref_clk_in);
    end
    $display("test sweep k=%0d done", k);
  endtask

  task automatic close_out();
    $display("checks=%0d mismatches=%0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    logic [15:0] r;
    logic [5:0] k;
    logic [2:0] lc, hc;
    logic [7:0] v;
    int unsigned s;
    int f0;
    rstn_in = 1'b0;
    angle_in = 8'h00;
    field_strength_in = 8'h50;
    repeat (10) @(posedge ref_clk_in);
    rstn_in <= 1'b1;
    repeat (6) @(posedge ref_clk_in);
    s = $urandom(32'h81F4);
    u_host.xfer({CMD_READ, ADDR_PULSES_PER_TURN_LOW, 8'h00}, r);
    for (int i = 0; i < 5; i++) begin
      u_host.xfer({CMD_READ, RA[i], 8'h00}, r);
      `CHK(r[15:8], EV[i])
    end
    $display("test reset_values done");
    sweep(63);
    // Dither of one angle step must not move the outputs.
    f0 = n_fwd + n_rev;
    for (int n = 0; n < 20; n++) begin
      angle_in <= 8'(n % 2);
      repeat (16) @(posedge ref_clk_in);
    end
    `CHK(n_fwd + n_rev, f0)
    $display("test hysteresis done");
    for (int j = 0; j < 2; j++) begin
      k = (j == 0) ? 6'h00 : 6'($urandom_range(62, 1));
      u_host.wr(ADDR_PULSES_PER_TURN_LOW, {k[1:0], 6'h00});
      u_host.wr(ADDR_PULSES_PER_TURN_HIGH, {4'h0, k[5:2]});
      sweep(int'(k));
    end
    lc = 3'($urandom_range(7, 4));
    hc = 3'($urandom_range(3, 0));
    eh = 1'b0;
    el = 1'b0;
    u_host.wr(ADDR_FIELD_THRESHOLDS, {lc, hc, 2'b00});
    for (int n = 0; n < 41; n++) begin
      v = (n == 0) ? 8'h50 : 8'($urandom_range(140, 0));
      field_strength_in <= v;
      eh = nxt(eh, v, hc, 1'b1);
      el = nxt(el, v, lc, 1'b0);
      repeat (5) @(posedge ref_clk_in);
      `CHK({field_high_flag_out, field_low_flag_out}, {eh, el})
    end
    u_host.xfer({CMD_READ, ADDR_FIELD_FLAGS, 8'h00}, r);
    u_host.xfer({CMD_READ, ADDR_FIELD_FLAGS, 8'h00}, r);
    `CHK(r[15:14], {eh, el})
    $display("test field_flags done");
    close_out();
  end

  initial begin
    repeat (80000) @(posedge ref_clk_in);
    miscompares++;
    close_out();
  end
endmodule // abz_encoder_and_field_flags_tb_top

`default_nettype wire
